// ==== shared/slpm_regs.svh ====
`ifndef SLPM_REGS_SVH
`define SLPM_REGS_SVH
// Function-select field codes
`define SLPM_FSEL_INDICATOR 2'h0
`define SLPM_FSEL_IRQ 2'h1
`define SLPM_FSEL_WAKE 2'h2
`define SLPM_FSEL_LINK_ACT 2'h3
// Reset values of the strap latches
`define SLPM_REGULATOR_OFF_STRAP_RST 1'h0
`define SLPM_INTSEL_RST 1'h1
// Idle levels of the reset pins, so no false edge follows reset
`define SLPM_POR_IDLE 1'h0
`define SLPM_EXT_RESET_N_IDLE 1'h1
// Reset levels of the output pins
`define SLPM_FIRST_PIN_RST 1'h0
`define SLPM_SECOND_PIN_RST 1'h1
`define SLPM_IRQ_N_IDLE 1'h1
`define SLPM_TXE_IDLE 1'h0
// Blink half period in cycles of the 50 MHz clock
`define SLPM_CLK_MHZ 50
`define SLPM_BLINK_HALF_MS 50
`define SLPM_BLINK_HALF_CYC (`SLPM_BLINK_HALF_MS * 1000 * `SLPM_CLK_MHZ)
`endif

// ==== shared/slpm_pkg.sv ====
package slpm_pkg;
   // Link state seen by the indicators
   typedef struct packed {
      logic link_up;
      logic carrier;
      logic speed_100;
      logic isolated;
   } slpm_link_t;
   // Latched strap picture
   typedef struct packed {
      logic regulator_off;
      logic irq_select;
   } slpm_strap_t;
endpackage : slpm_pkg

// ==== design/slpm_sync.sv ====
`timescale 1ns/100ps
module slpm_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // Asynchronous level in, filtered level out
   input wire logic [WIDTH-1:0] async_i,
   input wire logic [WIDTH-1:0] reset_val_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;
   logic [WIDTH-1:0] out_reg;
   logic primed_reg;

   if (WIDTH < 1)
   begin : g_bad_width
      $error("slpm_sync: WIDTH below one");
   end

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
      end
      else if (clk_en_i)
      begin
         stage1_reg <= async_i;
         // Seed the compare stages so reset zeros never look like a change
         if (!primed_reg)
         begin
            stage2_reg <= reset_val_i;
            stage3_reg <= reset_val_i;
         end
         else
         begin
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
         end
      end
   end

   // A change counts once stages two and three agree
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         out_reg <= '0;
         primed_reg <= 1'b0;
      end
      else if (clk_en_i)
      begin
         primed_reg <= 1'b1;
         if (!primed_reg)
            out_reg <= reset_val_i;
         else
            for (int i = 0; i < WIDTH; i++)
               if (stage2_reg[i] == stage3_reg[i])
                  out_reg[i] <= stage3_reg[i];
      end
   end

   assign sync_o = primed_reg ? out_reg : reset_val_i;
endmodule : slpm_sync

// ==== design/slpm_pin_mux.sv ====
`timescale 1ns/100ps
`include "slpm_regs.svh"
module slpm_pin_mux #(
   parameter int BLINK_HALF_CYC = `SLPM_BLINK_HALF_CYC
) (
   // Clock, reset, enable
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // Power-on and external reset pins
   input wire logic power_on_i,
   input wire logic ext_reset_n_i,
   // Strap pins
   input wire logic regulator_off_strap_i,
   input wire logic irq_pin_select_strap_i,
   // Function select fields of the wake control/status register
   input wire logic [1:0] first_fsel_i,
   input wire logic [1:0] second_fsel_i,
   // Link state and event sources
   input wire slpm_pkg::slpm_link_t link_i,
   input wire logic irq_active_i,
   input wire logic wake_active_i,
   input wire logic tx_err_i,
   // Pins and status
   output logic regulator_en_o,
   output logic irq_out_n_o,
   output logic tx_err_bit4_o,
   output logic shared_is_irq_o,
   output logic first_indicator_pin_o,
   output logic second_indicator_pin_o,
   output slpm_pkg::slpm_strap_t strap_o
);
   import slpm_pkg::*;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [3:0] pin_sync;
   logic por_s;
   logic ext_reset_n_s;
   logic regulator_off_strap_s;
   logic intsel_s;

   if (BLINK_HALF_CYC < 1)
   begin : g_bad_blink
      $error("slpm_pin_mux: BLINK_HALF_CYC below one");
   end

   slpm_sync #(.WIDTH(4)) slpm_sync_inst (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .async_i({power_on_i, ext_reset_n_i, regulator_off_strap_i, irq_pin_select_strap_i}),
      .reset_val_i({`SLPM_POR_IDLE, `SLPM_EXT_RESET_N_IDLE, `SLPM_REGULATOR_OFF_STRAP_RST, `SLPM_INTSEL_RST}),
      .sync_o(pin_sync)
   );
   assign {por_s, ext_reset_n_s, regulator_off_strap_s, intsel_s} = pin_sync;

   // ----------------------------------------
   // Strap latching
   // ----------------------------------------
   logic por_d_reg;
   logic ext_reset_n_d_reg;
   logic por_rise;
   logic ext_reset_n_rise;
   slpm_strap_t strap_reg;

   assign por_rise = por_s && !por_d_reg;
   assign ext_reset_n_rise = ext_reset_n_s && !ext_reset_n_d_reg;

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         por_d_reg <= `SLPM_POR_IDLE;
         ext_reset_n_d_reg <= `SLPM_EXT_RESET_N_IDLE;
      end
      else if (clk_en_i)
      begin
         por_d_reg <= por_s;
         ext_reset_n_d_reg <= ext_reset_n_s;
      end
   end

   // Regulator strap only at power-on; select strap also on reset rise
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         strap_reg.regulator_off <= `SLPM_REGULATOR_OFF_STRAP_RST;
         strap_reg.irq_select <= `SLPM_INTSEL_RST;
      end
      else if (clk_en_i)
      begin
         if (por_rise)
            strap_reg.regulator_off <= regulator_off_strap_s;
         if (por_rise || ext_reset_n_rise)
            strap_reg.irq_select <= intsel_s;
      end
   end

   assign strap_o = strap_reg;

   // ----------------------------------------
   // Activity blink
   // ----------------------------------------
   logic [31:0] blink_cnt_reg;
   logic blink_reg;

   // Blink runs only with carrier so a steady link shows solid
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         blink_cnt_reg <= 32'h0;
         blink_reg <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (!link_i.carrier)
         begin
            blink_cnt_reg <= 32'h0;
            blink_reg <= 1'b0;
         end
         else if (blink_cnt_reg == 32'(BLINK_HALF_CYC - 1))
         begin
            blink_cnt_reg <= 32'h0;
            blink_reg <= !blink_reg;
         end
         else
            blink_cnt_reg <= blink_cnt_reg + 32'h1;
      end
   end

   // ----------------------------------------
   // Pin functions
   // ----------------------------------------
   logic link_act;
   logic link_speed;
   logic first_next;
   logic second_next;

   assign link_act = link_i.link_up && !blink_reg;
   assign link_speed = link_i.speed_100 && !link_i.isolated;

   // Apply polarity: active level drives pin to 0 when polarity high
   // Every source is an argument, so the assign sees all its operands
   function automatic logic slpm_pick(input logic [1:0] fsel, input logic ind,
                                      input logic act, input logic act_low,
                                      input logic irq, input logic wake);
      logic v;
      v = 1'h0;
      unique case (fsel)
         `SLPM_FSEL_INDICATOR: v = ind ^ act_low;
         `SLPM_FSEL_IRQ: v = !irq;
         `SLPM_FSEL_WAKE: v = !wake;
         `SLPM_FSEL_LINK_ACT: v = act ^ act_low;
      endcase
      return v;
   endfunction : slpm_pick

   // Reset selects are zero, so indicators start in their default roles
   assign first_next = slpm_pick(first_fsel_i, link_act, link_act, strap_reg.regulator_off,
                                 irq_active_i, wake_active_i);
   assign second_next = slpm_pick(second_fsel_i, link_speed, link_act, strap_reg.irq_select,
                                  irq_active_i, wake_active_i);

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         first_indicator_pin_o <= `SLPM_FIRST_PIN_RST;
         second_indicator_pin_o <= `SLPM_SECOND_PIN_RST;
         irq_out_n_o <= `SLPM_IRQ_N_IDLE;
         tx_err_bit4_o <= `SLPM_TXE_IDLE;
      end
      else if (clk_en_i)
      begin
         first_indicator_pin_o <= first_next;
         second_indicator_pin_o <= second_next;
         // Only one function live on the shared pin
         irq_out_n_o <= strap_reg.irq_select ? !irq_active_i : `SLPM_IRQ_N_IDLE;
         tx_err_bit4_o <= strap_reg.irq_select ? `SLPM_TXE_IDLE : tx_err_i;
      end
   end

   assign regulator_en_o = !strap_reg.regulator_off;
   assign shared_is_irq_o = strap_reg.irq_select;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence pwr_rise_s;
      clk_en_i && por_rise;
   endsequence

   regulator_off_strap_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !por_rise |=> $stable(strap_reg.regulator_off))
      else $error("Regulator strap changed without power-on");
   intsel_cap_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (clk_en_i && (por_rise || ext_reset_n_rise)) |=> strap_reg.irq_select == $past(intsel_s))
      else $error("Select strap not captured");
   intsel_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !(por_rise || ext_reset_n_rise) |=> $stable(strap_reg.irq_select))
      else $error("Select strap changed between resets");
   reg_enable_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      pwr_rise_s |=> regulator_en_o == !$past(regulator_off_strap_s))
      else $error("Regulator enable wrong");
   shared_irq_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (clk_en_i && strap_reg.irq_select && irq_active_i) ##1 strap_reg.irq_select
      |-> !irq_out_n_o)
      else $error("Interrupt not on shared pin");
   shared_txe_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (clk_en_i && !strap_reg.irq_select) |=> irq_out_n_o)
      else $error("Interrupt on shared pin in transmit mode");
   first_pol_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (clk_en_i && first_fsel_i == `SLPM_FSEL_INDICATOR && !link_i.link_up
       && strap_reg.regulator_off) |=> first_indicator_pin_o)
      else $error("First indicator polarity wrong");
   second_pol_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (clk_en_i && second_fsel_i == `SLPM_FSEL_INDICATOR && link_speed
       && !strap_reg.irq_select) |=> second_indicator_pin_o)
      else $error("Second indicator speed wrong");
   second_act_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (clk_en_i && second_fsel_i == `SLPM_FSEL_LINK_ACT)
      |=> second_indicator_pin_o == ($past(link_act) ^ $past(strap_reg.irq_select)))
      else $error("Second indicator not link activity");
   wake_route_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (clk_en_i && first_fsel_i == `SLPM_FSEL_WAKE)
      |=> first_indicator_pin_o == !$past(wake_active_i))
      else $error("Wake not routed to first indicator");
endmodule : slpm_pin_mux

// ==== bench/slpm_host_model.sv ====
`timescale 1ns/100ps
`include "slpm_regs.svh"
module slpm_host_model
(
   // Board strap fitting and system features
   input wire logic reg_off_fit_i,
   input wire logic irq_sel_level_i,
   input wire logic eee_en_i,
   input wire logic wol_en_i,
   // Function requests from host software
   input wire logic [1:0] first_req_i,
   input wire logic [1:0] second_req_i,
   // Strap levels and select fields seen by the device
   output logic regulator_off_strap_o,
   output logic irq_pin_select_strap_o,
   output logic [1:0] first_fsel_o,
   output logic [1:0] second_fsel_o
);
   // ----------------------------------------
   // Straps and routing
   // ----------------------------------------
   // Unfitted regulator strap reads low through its pull-down
   assign regulator_off_strap_o = reg_off_fit_i;
   // EEE boards need the shared pin for transmit error
   assign irq_pin_select_strap_o = irq_sel_level_i && !eee_en_i;
   // Interrupt and wake lose the shared pin, so indicators carry them
   assign first_fsel_o = (eee_en_i && wol_en_i) ? `SLPM_FSEL_IRQ : first_req_i;
   assign second_fsel_o = (eee_en_i && wol_en_i) ? `SLPM_FSEL_WAKE : second_req_i;
endmodule : slpm_host_model

// ==== bench/tb_slpm_pin_mux.sv ====
`timescale 1ns/100ps
`include "slpm_regs.svh"
`define SLPM_CHK(a, e) begin checked++; if ((a) !== (e)) begin \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); num_errors++; end end
module tb_slpm_pin_mux;
   import slpm_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic sys_clk_i = 1'h0;
   logic reset_i = 1'h1;
   logic clk_en = 1'h1;
   logic power_on = 1'h0, ext_reset_n = 1'h1;
   logic reg_fit = 1'h0, sel_level = 1'h1, eee = 1'h0, wol = 1'h0;
   logic [1:0] first_req = 2'h0, second_req = 2'h0, first_fsel, second_fsel;
   logic reg_strap, sel_strap, irq_act = 1'h0, wake_act = 1'h0, tx_err = 1'h0;
   slpm_link_t link = '0;
   logic reg_en, irq_n, tx_b4, is_irq, pin1, pin2;
   slpm_strap_t strap;
   int num_errors = 0, checked = 0, cycles = 0;
   always #10 sys_clk_i = ~sys_clk_i;
   // ----------------------------------------
   // Instances
   // ----------------------------------------
   slpm_host_model slpm_host_model_inst (.reg_off_fit_i(reg_fit), .irq_sel_level_i(sel_level),
      .eee_en_i(eee), .wol_en_i(wol), .first_req_i(first_req), .second_req_i(second_req),
      .regulator_off_strap_o(reg_strap), .irq_pin_select_strap_o(sel_strap),
      .first_fsel_o(first_fsel), .second_fsel_o(second_fsel));
   // Short blink so a whole period fits in a few cycles
   slpm_pin_mux #(.BLINK_HALF_CYC(4)) slpm_pin_mux_inst (.sys_clk_i(sys_clk_i),
      .reset_i(reset_i), .clk_en_i(clk_en), .power_on_i(power_on), .ext_reset_n_i(ext_reset_n),
      .regulator_off_strap_i(reg_strap), .irq_pin_select_strap_i(sel_strap),
      .first_fsel_i(first_fsel), .second_fsel_i(second_fsel), .link_i(link),
      .irq_active_i(irq_act), .wake_active_i(wake_act), .tx_err_i(tx_err),
      .regulator_en_o(reg_en), .irq_out_n_o(irq_n), .tx_err_bit4_o(tx_b4),
      .shared_is_irq_o(is_irq), .first_indicator_pin_o(pin1),
      .second_indicator_pin_o(pin2), .strap_o(strap));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task test_done;
      if (num_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   task cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : cyc
   // Pulse gives the synchroniser a clean low before the rising edge
   task power_up;
      power_on = 1'h0;
      cyc(5);
      power_on = 1'h1;
      cyc(8);
   endtask : power_up
   task ext_rst;
      ext_reset_n = 1'h0;
      cyc(5);
      ext_reset_n = 1'h1;
      cyc(8);
   endtask : ext_rst
   // ----------------------------------------
   // Timeout
   // ----------------------------------------
   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles >= 3000)
      begin
         num_errors++;
         test_done();
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      cyc(8);
      reset_i = 1'h0;
      cyc(6);
      `SLPM_CHK(reg_en, 1'h1)
      `SLPM_CHK(is_irq, 1'h1)
      `SLPM_CHK({irq_n, tx_b4, pin1, pin2}, 4'h9)
      // Regulator strap high, select strap floating high
      reg_fit = 1'h1;
      power_up();
      link = '{link_up: 1'h1, carrier: 1'h0, speed_100: 1'h1, isolated: 1'h0};
      irq_act = 1'h1;
      cyc(2);
      `SLPM_CHK(strap, 2'h3)
      `SLPM_CHK({reg_en, is_irq, irq_n, tx_b4}, 4'h4)
      `SLPM_CHK({pin1, pin2}, 2'h0)
      link.isolated = 1'h1;
      link.link_up = 1'h0;
      cyc(2);
      `SLPM_CHK({pin1, pin2}, 2'h3)
      // Clock enable low freezes the pins
      clk_en = 1'h0;
      link.link_up = 1'h1;
      link.isolated = 1'h0;
      cyc(3);
      `SLPM_CHK({pin1, pin2}, 2'h3)
      clk_en = 1'h1;
      cyc(2);
      `SLPM_CHK({pin1, pin2}, 2'h0)
      // External reset resamples only the select strap
      reg_fit = 1'h0;
      eee = 1'h1;
      tx_err = 1'h1;
      link.isolated = 1'h0;
      ext_rst();
      `SLPM_CHK(strap, 2'h2)
      `SLPM_CHK({reg_en, is_irq, irq_n, tx_b4}, 4'h3)
      `SLPM_CHK(pin2, 1'h1)
      // Both features on: interrupt and wake on the indicators
      wol = 1'h1;
      for (int i = 0; i < 2; i++)
      begin
         irq_act = (i == 0);
         wake_act = (i == 1);
         cyc(2);
         `SLPM_CHK({pin1, pin2}, (i == 0) ? 2'h1 : 2'h2)
      end
      wol = 1'h0;
      // Wake on the first indicator, interrupt on the second; shared pin stays on transmit error
      first_req = `SLPM_FSEL_WAKE;
      second_req = `SLPM_FSEL_IRQ;
      cyc(2);
      `SLPM_CHK({pin1, pin2}, 2'h1)
      irq_act = 1'h1;
      cyc(2);
      `SLPM_CHK(pin2, 1'h0)
      first_req = `SLPM_FSEL_INDICATOR;
      second_req = `SLPM_FSEL_INDICATOR;
      // Second power-on picks up the regulator strap again
      link.link_up = 1'h1;
      power_up();
      `SLPM_CHK({strap, reg_en}, 3'h1)
      `SLPM_CHK(pin1, 1'h1)
      reg_fit = 1'h1;
      eee = 1'h0;
      cyc(10);
      `SLPM_CHK(strap, 2'h0)
      // Link/activity moved to the second indicator, then blinking
      second_req = `SLPM_FSEL_LINK_ACT;
      cyc(2);
      `SLPM_CHK(pin2, 1'h1)
      link.carrier = 1'h1;
      cyc(3);
      `SLPM_CHK(pin2, 1'h1)
      cyc(4);
      `SLPM_CHK(pin2, 1'h0)
      `SLPM_CHK(pin1, 1'h0)
      cyc(4);
      `SLPM_CHK(pin2, 1'h1)
      test_done();
   end
endmodule : tb_slpm_pin_mux
